// File: desc_decode.sv
// Module: combinational decode of one descriptor access byte.
`timescale 1ns/1ps
module desc_decode
  import seg_prot_pkg::*;
(
  input wire logic [7:0] access,
  output logic is_code,
  output logic is_data,
  output logic is_sys_seg,
  output logic is_gate,
  output logic [2:0] sys_type,
  output logic present,
  output logic [1:0] level
);

  // ==========================================================================
  // Class decode
  // ==========================================================================
  // Bit 4 splits segments from system and gate descriptors.
  assign is_code = access[AB_SEG] & access[AB_RUN];     // [RULE_08]
  assign is_data = access[AB_SEG] & ~access[AB_RUN];    // [RULE_08]
  assign sys_type = access[2:0];
  // The type field fills bits 3 to 0: types 1 to 3 are system segments,
  // and 4 to 7 are gates, so bit 3 is clear and bit 2 splits the groups.
  assign is_sys_seg = ~access[AB_SEG] & ~access[AB_RUN] & ~access[AB_GROW] &
                      (access[1:0] != 2'b00);           // [RULE_09]
  assign is_gate = ~access[AB_SEG] & ~access[AB_RUN] &
                   access[AB_GROW];                     // [RULE_12]
  assign present = access[AB_PRESENT];
  assign level = access[AB_LVL_LO +: 2];

endmodule : desc_decode

// File: desc_mem.sv
// Partner model: descriptor memory answering each word after a delay.
`timescale 1ns/1ps
module desc_mem
(
  input wire logic clk,
  input wire logic [3:0] delay,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  // ====================
  // Word store and reply
  // ====================
  logic [15:0] store [0:127];
  logic [3:0] cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'hA5A5;
  // One answer per word; between answers the data lines invert every cycle,
  // so a design that samples late sees the word or its inverse by turns.
  always @(posedge clk)
  begin
    if (mem_req && !mem_ack && cnt >= delay)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= store[mem_addr[7:1]];
      if (mem_write)
        store[mem_addr[7:1]] <= mem_wdata;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    cnt <= (mem_req && !mem_ack && cnt < delay) ? cnt + 4'h1 : 4'h0;
  end
endmodule : desc_mem

// File: limit_check.sv
// Module: offset versus limit test for one cached segment.
`timescale 1ns/1ps
module limit_check
(
  input wire logic [15:0] offset,
  input wire logic [15:0] limit,
  input wire logic grow_down,
  output logic in_range
);

  // ==========================================================================
  // Range test
  // ==========================================================================
  // Upward segments end at the limit; downward ones start just above it.
  assign in_range = grow_down ? (offset > limit) : (offset <= limit);

endmodule : limit_check

// File: seg_prot_pkg.sv
// Package: constants for segment descriptor protection logic.
package seg_prot_pkg;

  // ==========================================================================
  // Access byte layout
  // ==========================================================================
  localparam int AB_USED = 0;
  localparam int AB_RW = 1;
  localparam int AB_GROW = 2;
  localparam int AB_RUN = 3;
  localparam int AB_SEG = 4;
  localparam int AB_LVL_LO = 5;
  localparam int AB_PRESENT = 7;

  // ==========================================================================
  // System and gate type codes
  // ==========================================================================
  localparam logic [2:0] TYPE_TASK_FREE = 3'h1;
  localparam logic [2:0] TYPE_LOCAL_TABLE = 3'h2;
  localparam logic [2:0] TYPE_TASK_BUSY = 3'h3;
  localparam logic [2:0] TYPE_CALL_GATE = 3'h4;
  localparam logic [2:0] TYPE_TASK_GATE = 3'h5;
  localparam logic [2:0] TYPE_IRQ_GATE = 3'h6;
  localparam logic [2:0] TYPE_TRAP_GATE = 3'h7;

  // ==========================================================================
  // Exception vectors and geometry
  // ==========================================================================
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_PROTECTION = 8'h0D;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam int DESC_SHIFT = 3;
  localparam logic [15:0] DESC_LAST_BYTE = 16'h0007;
  localparam int WORD_COUNT_W = 5;

  // Access kinds requested of a cached segment.
  typedef enum logic [1:0] {
    ACC_READ = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_EXEC = 2'b10
  } access_e;

  // Load purposes: segment register index, gate dispatch or descriptor test.
  typedef enum logic [2:0] {
    LD_CODE = 3'b000,
    LD_STACK = 3'b001,
    LD_DATA = 3'b010,
    LD_EXTRA = 3'b011,
    LD_GATE = 3'b100,
    LD_TEST = 3'b101
  } load_e;

endpackage : seg_prot_pkg

// File: seg_protect.sv
// Module: descriptor fetch, check and cache for four segment registers.
// What this block does
// RULE_01: Data segment writes are refused unless the writable bit is set.
// RULE_02: Shared-privilege code runs only when current ring >= its level.
// RULE_03: Code is never written; read only when its readable bit is set.
// RULE_04: The used bit is written back set whenever a descriptor is accessed; here only when it passes the type and present tests, not for a gate target.
// RULE_05: A not-present code or data descriptor aborts use, not-present fault.
// RULE_06: Grow-down bit picks expansion direction of data segments.
// RULE_07: Code segment limit is the offset of its last valid byte.
// RULE_08: Access bit 4 separates segments from system; run bit marks code.
// RULE_09: System types 1, 2, 3 are free task, local table, busy task.
// RULE_10: System descriptors give 24-bit base, 16-bit limit, valid if present.
// RULE_11: Level is checked for task state blocks, ignored for local tables.
// RULE_12: Gate types 4 to 7 are call, task, interrupt and trap gates.
// RULE_13: Interrupt gates clear the interrupt enable; trap gates keep it.
// RULE_14: Gate target must be code, or task state for task gates, else 13.
// RULE_15: Call gate word count is copied on ring change, ignored otherwise.
// RULE_16: A not-present gate is invalid and raises exception 11.
// RULE_17: Software builds gate descriptors with access bit 4 clear.
// RULE_18: One hidden cache per segment register, loaded on selector load.
// RULE_19: Caches are not readable by programs and change only on load.
// RULE_20: Upper 13 selector bits index; low bits are table and ring.
// RULE_21: Tables hold up to 8192 entries, 24-bit base, 16-bit limit.
// RULE_22: A selector beyond the table limit raises exception 13.
// RULE_23: Grow-up offsets must not pass limit; grow-down must exceed it.
// RULE_24: Descriptors are eight bytes, fetched automatically on loads.
// RULE_25: Descriptor memory accesses are locked bus operations.
// RULE_26: Requested ring is the two low selector bits.
// RULE_27: Table select 0 is global, 1 local; address is base plus 8*index.
// RULE_28: A fault leaves the segment register and its cache unchanged.
`timescale 1ns/1ps
module seg_protect
  import seg_prot_pkg::*;
#(
  parameter int NUM_SEGS = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  // Table registers, loaded by logic outside this block.
  input wire logic [23:0] global_base,
  input wire logic [15:0] global_limit,
  input wire logic [23:0] local_base,
  input wire logic [15:0] local_limit,
  input wire logic [1:0] current_ring,
  // Load request from the execution unit.
  input wire logic load_req,
  input wire logic [2:0] load_kind,
  input wire logic [15:0] load_selector,
  output logic load_busy,
  output logic load_done,
  output logic [7:0] fault_vector,
  output logic [15:0] fault_code,
  // Gate dispatch results.
  output logic [2:0] gate_type,
  output logic [15:0] gate_dest_selector,
  output logic [15:0] gate_dest_offset,
  output logic [4:0] gate_copy_words,
  output logic irq_enable_clear,
  // Descriptor memory port: 16-bit words, locked.
  output logic mem_req,
  output logic mem_write,
  output logic mem_lock,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Reference check on a cached segment.
  input wire logic [1:0] ref_seg,
  input wire logic [1:0] ref_kind,
  input wire logic [15:0] ref_offset,
  output logic ref_ok,
  output logic [7:0] ref_vector,
  output logic [23:0] ref_base,
  // Visible segment registers.
  output logic [15:0] code_seg,
  output logic [15:0] stack_seg,
  output logic [15:0] data_seg,
  output logic [15:0] extra_seg
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (NUM_SEGS != 4)
  begin : g_bad_segs
    $error("seg_protect serves exactly four segment registers");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_MARK = 3'b010,
    ST_DONE = 3'b011,
    ST_FAULT = 3'b100,
    ST_DEST = 3'b101
  } state_e;

  state_e state;
  state_e next_state;
  logic [1:0] word_idx;
  logic [15:0] desc_w [4];
  logic [2:0] kind;
  logic [15:0] sel;
  logic [7:0] vec;
  logic [15:0] seg_reg [4];
  logic [23:0] c_base [4];
  logic [15:0] c_limit [4];
  logic [7:0] c_access [4];
  logic c_valid [4];

  // ==========================================================================
  // Selector fields and table address
  // ==========================================================================
  wire [12:0] sel_index = load_selector[15:3];          // [RULE_20]
  wire sel_local = load_selector[2];                    // [RULE_20]
  wire [1:0] requested_ring = load_selector[1:0];       // [RULE_26]
  wire [23:0] tbl_base = sel_local ? local_base : global_base; // [RULE_27]
  wire [15:0] tbl_limit = sel_local ? local_limit : global_limit; // [RULE_21]
  // Index times eight; whole entry must lie within the limit.
  wire [15:0] entry_off = {sel_index, 3'b000};          // [RULE_24]
  wire [16:0] entry_end = {1'b0, entry_off} + {1'b0, DESC_LAST_BYTE};
  wire over_limit = entry_end > {1'b0, tbl_limit};      // [RULE_22]
  wire null_sel = (sel_index == 13'h0000) && !sel_local;
  logic [23:0] entry_addr;

  // ==========================================================================
  // Descriptor decode
  // ==========================================================================
  wire [7:0] acc = desc_w[2][15:8];
  logic d_code;
  logic d_data;
  logic d_sys;
  logic d_gate;
  logic [2:0] d_type;
  logic d_present;
  logic [1:0] d_level;

  desc_decode u_dec (
    .access(acc),
    .is_code(d_code),
    .is_data(d_data),
    .is_sys_seg(d_sys),
    .is_gate(d_gate),
    .sys_type(d_type),
    .present(d_present),
    .level(d_level)
  );

  // Type test by purpose. Privilege compares beyond these are outside scope.
  wire is_seg_kind = (kind <= LD_EXTRA);
  wire conforming = acc[AB_GROW];
  wire code_ok = d_code && (!conforming ||
                 current_ring >= d_level);              // [RULE_02]
  // Stack needs writable data; data and extra accept readable code too.
  wire stack_ok = d_data && acc[AB_RW];                 // [RULE_01]
  wire dx_ok = d_data || (d_code && acc[AB_RW]);        // [RULE_03]
  wire task_blk = d_sys && (d_type == TYPE_TASK_FREE ||
                  d_type == TYPE_TASK_BUSY);            // [RULE_09]
  wire task_lvl_ok = current_ring <= d_level;           // [RULE_11]
  logic type_ok;
  always_comb
  begin
    unique case (kind)
      LD_CODE: type_ok = code_ok;
      LD_STACK: type_ok = stack_ok;
      LD_DATA, LD_EXTRA: type_ok = dx_ok;
      // A gate or a task state block may be referenced directly.
      LD_GATE: type_ok = d_gate || (task_blk && task_lvl_ok);
      LD_TEST: type_ok = d_code || d_data || d_sys || d_gate;
      default: type_ok = 1'b0;
    endcase
  end
  // Not-present segments and gates that pass the type test both yield vector 11.
  wire type_fault = !type_ok;                           // [RULE_14]
  wire pres_fault = !d_present;                         // [RULE_05] [RULE_16]
  // A gate's target access byte is fetched to check its kind.
  wire [15:0] dsel = desc_w[1];
  wire [23:0] dest_addr = (dsel[2] ? local_base : global_base) +
                          {8'h00, dsel[15:3], 3'b100};  // [RULE_14]
  wire [7:0] dest_acc = mem_rdata[15:8];
  wire dest_task = !dest_acc[AB_SEG] &&
                   (dest_acc[3:0] == {1'b0, TYPE_TASK_FREE} ||
                    dest_acc[3:0] == {1'b0, TYPE_TASK_BUSY});
  wire dest_ok = (d_type == TYPE_TASK_GATE) ? dest_task :
                 (dest_acc[AB_SEG] && dest_acc[AB_RUN]); // [RULE_14]

  // ==========================================================================
  // Next state
  // ==========================================================================
  wire start = (state == ST_IDLE) && load_req;
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (load_req)
          next_state = (over_limit || null_sel) ? ST_FAULT : ST_READ;
      ST_READ:
        if (mem_ack && word_idx == 2'd3)
          next_state = ST_MARK;
      ST_MARK:
        if (type_fault || pres_fault)
          next_state = ST_FAULT;
        else if (mem_ack)
          next_state = (kind == LD_GATE && d_gate) ? ST_DEST : ST_DONE;
      ST_DEST:
        if (mem_ack)
          next_state = dest_ok ? ST_DONE : ST_FAULT;    // [RULE_14]
      ST_DONE: next_state = ST_IDLE;
      ST_FAULT: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Fetch sequencing
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      word_idx <= 2'd0;
      kind <= LD_CODE;
      sel <= 16'h0000;
      entry_addr <= 24'h000000;
      vec <= VEC_NONE;
    end
    else
    begin
      state <= next_state;
      if (start)
      begin
        kind <= load_e'(load_kind);
        sel <= load_selector;
        entry_addr <= tbl_base + {8'h00, entry_off};    // [RULE_27]
        word_idx <= 2'd0;
        vec <= VEC_PROTECTION;                          // [RULE_22]
      end
      else if (state == ST_READ && mem_ack)
        word_idx <= word_idx + 2'd1;
      else if (state == ST_MARK)
        vec <= pres_fault && !type_fault ? VEC_NOT_PRESENT : VEC_PROTECTION;
    end
  end

  // Descriptor word capture; eight bytes as four words.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      for (int i = 0; i < 4; i++)
        desc_w[i] <= 16'h0000;
    else if (state == ST_READ && mem_ack)
      desc_w[word_idx] <= mem_rdata;                    // [RULE_24]
  end

  // ==========================================================================
  // Memory port
  // ==========================================================================
  // Lock spans read and write-back so the used bit update is atomic.
  wire marking = (state == ST_MARK) && !type_fault && !pres_fault;
  assign mem_req = (state == ST_READ) || marking || (state == ST_DEST);
  assign mem_write = marking;                           // [RULE_04]
  assign mem_lock = (state == ST_READ) || (state == ST_MARK) ||
                    (state == ST_DEST);                 // [RULE_25]
  assign mem_addr = (state == ST_DEST) ? dest_addr :
    entry_addr + {21'h000000, marking ? 2'd2 : word_idx, 1'b0};
  assign mem_wdata = desc_w[2] | (16'h0001 << (8 + AB_USED)); // [RULE_04]

  // ==========================================================================
  // Load results
  // ==========================================================================
  assign load_busy = (state != ST_IDLE);
  assign load_done = (state == ST_DONE) || (state == ST_FAULT);
  assign fault_vector = (state == ST_FAULT) ? vec : VEC_NONE;
  assign fault_code = (state == ST_FAULT) ? {sel[15:2], 2'b00} : 16'h0000;

  // Gate outputs are registered on completion.
  wire done_gate = (state == ST_DEST) && mem_ack && dest_ok;
  wire [2:0] g_type = d_type;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gate_type <= 3'h0;
      gate_dest_selector <= 16'h0000;
      gate_dest_offset <= 16'h0000;
      gate_copy_words <= 5'h00;
      irq_enable_clear <= 1'b0;
    end
    else
    begin
      irq_enable_clear <= done_gate && g_type == TYPE_IRQ_GATE; // [RULE_13]
      if (done_gate)
      begin
        gate_type <= g_type;                            // [RULE_12]
        gate_dest_selector <= desc_w[1];
        // Task gates carry no entry point.
        gate_dest_offset <= (g_type == TYPE_TASK_GATE) ? 16'h0000
                            : desc_w[0];                // [RULE_14]
        // Only a call gate whose target selector ring differs from the current ring copies words.
        gate_copy_words <= (g_type == TYPE_CALL_GATE &&
          desc_w[1][1:0] != current_ring) ?
          desc_w[2][WORD_COUNT_W-1:0] : 5'h00;          // [RULE_15]
      end
    end
  end

  // ==========================================================================
  // Hidden caches
  // ==========================================================================
  // Written only on a clean segment load; a fault leaves everything alone.
  wire seg_commit = (state == ST_MARK) && marking && mem_ack && is_seg_kind;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      for (int i = 0; i < 4; i++)
      begin
        seg_reg[i] <= 16'h0000;
        c_base[i] <= 24'h000000;
        c_limit[i] <= 16'h0000;
        c_access[i] <= 8'h00;
        c_valid[i] <= 1'b0;
      end
    else if (seg_commit)
    begin
      seg_reg[kind[1:0]] <= sel;                        // [RULE_18] [RULE_28]
      c_limit[kind[1:0]] <= desc_w[0];                  // [RULE_07]
      c_base[kind[1:0]] <= {desc_w[2][7:0], desc_w[1]}; // [RULE_10]
      c_access[kind[1:0]] <= acc | 8'h01;               // [RULE_19]
      c_valid[kind[1:0]] <= 1'b1;
    end
  end

  assign code_seg = seg_reg[0];
  assign stack_seg = seg_reg[1];
  assign data_seg = seg_reg[2];
  assign extra_seg = seg_reg[3];

  // ==========================================================================
  // Reference checks served from the cache
  // ==========================================================================
  wire [7:0] r_acc = c_access[ref_seg];
  wire r_code = r_acc[AB_RUN];
  wire r_grow = !r_code && r_acc[AB_GROW];              // [RULE_06]
  logic r_range;
  limit_check u_lim (
    .offset(ref_offset),
    .limit(c_limit[ref_seg]),
    .grow_down(r_grow),
    .in_range(r_range)                                  // [RULE_23]
  );
  logic r_attr;
  always_comb
  begin
    unique case (ref_kind)
      ACC_WRITE: r_attr = !r_code && r_acc[AB_RW];      // [RULE_01] [RULE_03]
      ACC_EXEC: r_attr = r_code && (!r_acc[AB_GROW] ||
        current_ring >= r_acc[AB_LVL_LO +: 2]);         // [RULE_02]
      default: r_attr = !r_code || r_acc[AB_RW];        // [RULE_03]
    endcase
  end
  wire r_present = c_valid[ref_seg] && r_acc[AB_PRESENT]; // [RULE_05]
  assign ref_ok = r_present && r_attr && r_range;
  assign ref_vector = !r_present ? VEC_NOT_PRESENT :
                      (ref_ok ? VEC_NONE : VEC_PROTECTION);
  assign ref_base = c_base[ref_seg];                    // [RULE_18]

endmodule : seg_protect

// File: seg_protect_props.sv
// Checker: port-level properties of the segment protection block.
`timescale 1ns/1ps
module seg_protect_props
  import seg_prot_pkg::*;
#(
  parameter int NUM_SEGS = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] global_limit,
  input wire logic load_req,
  input wire logic [15:0] load_selector,
  input wire logic load_busy,
  input wire logic load_done,
  input wire logic [7:0] fault_vector,
  input wire logic [15:0] fault_code,
  input wire logic irq_enable_clear,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_lock,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] code_seg,
  input wire logic [15:0] data_seg
);
  // ==========
  // Properties
  // ==========
  // All checks rest while reset is held, since state is forced then.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire take = load_req && !load_busy;
  wire far = {load_selector[15:3], 3'h7} > global_limit;

  AST_LOCKED:
    assert property (mem_req |-> mem_lock) else $error("unlocked access");
  AST_MARK:
    assert property (mem_req && mem_write |-> mem_addr[2:0] == 3'h4
      && mem_wdata[8]) else $error("write-back not used bit");
  AST_HOLD:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("request dropped before answer");
  AST_LIMIT:
    assert property (take && !load_selector[2] && far |=> load_done
      && fault_vector == VEC_PROTECTION && !mem_req)
      else $error("beyond-limit selector not refused");
  AST_END:
    assert property (take |-> ##[1:200] load_done)
      else $error("load never finished");
  AST_KEEP:
    assert property (load_done && fault_vector != VEC_NONE
      |=> $stable(code_seg) && $stable(data_seg))
      else $error("fault changed a segment");
  AST_CODE:
    assert property (load_done && fault_vector != VEC_NONE
      |-> fault_code[1:0] == 2'b00) else $error("fault code ring bits");
  AST_IRQ:
    assert property (irq_enable_clear |-> load_done
      && fault_vector == VEC_NONE) else $error("stray enable clear");

  cover property (take ##[1:200] load_done && fault_vector == VEC_NONE);
  cover property (irq_enable_clear);
  cover property (mem_write && mem_ack);
endmodule : seg_protect_props

bind seg_protect seg_protect_props #(.NUM_SEGS(NUM_SEGS)) props_u (
  .clk, .nrst, .global_limit, .load_req, .load_selector, .load_busy,
  .load_done, .fault_vector, .fault_code, .irq_enable_clear, .mem_req,
  .mem_write, .mem_lock, .mem_addr, .mem_wdata, .mem_ack, .code_seg,
  .data_seg
);

// File: test_seg_protect.sv
// Testbench: directed loads and references through the protection block.
`timescale 1ns/1ps
module test_seg_protect
  import seg_prot_pkg::*;
;
  // =======
  // Signals
  // =======
  logic clk, nrst, load_req, load_busy, load_done, irq_enable_clear, irq;
  logic mem_req, mem_write, mem_lock, mem_ack, ref_ok;
  logic [1:0] current_ring, ref_seg, ref_kind;
  logic [2:0] load_kind, gate_type;
  logic [3:0] delay;
  logic [4:0] gate_copy_words;
  logic [7:0] fault_vector, ref_vector;
  logic [15:0] load_selector, fault_code, gate_dest_selector;
  logic [15:0] gate_dest_offset, mem_wdata, mem_rdata, ref_offset;
  logic [15:0] code_seg, stack_seg, data_seg, extra_seg;
  logic [23:0] mem_addr, ref_base;
  int n_errors = 0;
  int compares = 0;

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Tables: global entries 0..15 at 0x00, local ones at 0x80.
  seg_protect #(.NUM_SEGS(4)) dut_u (
    .clk, .nrst, .global_base(24'h000000), .global_limit(16'h007F),
    .local_base(24'h000080), .local_limit(16'h007F), .current_ring,
    .load_req, .load_kind, .load_selector, .load_busy, .load_done,
    .fault_vector, .fault_code, .gate_type, .gate_dest_selector,
    .gate_dest_offset, .gate_copy_words, .irq_enable_clear, .mem_req,
    .mem_write, .mem_lock, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .ref_seg, .ref_kind, .ref_offset, .ref_ok, .ref_vector, .ref_base,
    .code_seg, .stack_seg, .data_seg, .extra_seg
  );
  desc_mem mem_u (.clk, .delay, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);

  // =====
  // Tasks
  // =====
  task check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check

  // Entry a: word0, words 1 and base/count byte, access byte.
  task put(input int a, input logic [15:0] w0, input logic [23:0] w1,
    input logic [7:0] acc);
    mem_u.store[a*4] = w0;
    mem_u.store[a*4+1] = w1[15:0];
    mem_u.store[a*4+2] = {acc, w1[23:16]};
    mem_u.store[a*4+3] = 16'h0000;
  endtask : put

  // Request held for one clock, then wait for the done pulse.
  task load(input logic [2:0] kind, input logic [15:0] sel,
    input logic [7:0] vec);
    int n;
    @(negedge clk);
    load_req = 1'b1;
    load_kind = kind;
    load_selector = sel;
    @(negedge clk);
    load_req = 1'b0;
    n = 0;
    while (load_done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    irq = irq_enable_clear;
    check(load_done === 1'b1 && fault_vector === vec, "load result");
  endtask : load

  task ref_chk(input logic [1:0] seg, input logic [1:0] kind,
    input logic [15:0] off, input logic ok);
    @(negedge clk);
    ref_seg = seg;
    ref_kind = kind;
    ref_offset = off;
    #1;
    check(ref_ok === ok, "reference verdict");
  endtask : ref_chk

  task gate(input logic [15:0] sel, input logic [2:0] typ,
    input logic [15:0] dsel, input logic [4:0] wc, input logic clr);
    load(LD_GATE, sel, VEC_NONE);
    @(negedge clk);
    check(gate_type === typ && gate_dest_selector === dsel
      && gate_copy_words === wc && irq === clr, "gate result");
  endtask : gate

  task wrap_up;
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Whole run needs a few hundred cycles; this cuts a hang short.
  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end

  // ========
  // Sequence
  // ========
  initial
  begin
    nrst = 1'b0;
    load_req = 1'b0;
    load_kind = 3'h0;
    load_selector = 16'h0000;
    current_ring = 2'h3;
    ref_seg = 2'h2;
    ref_kind = 2'h0;
    ref_offset = 16'h0000;
    delay = 4'h0;
    irq = 1'b0;
    put(1, 16'h00FF, 24'h012340, 8'hF2);
    put(2, 16'h0FFF, 24'h020000, 8'hF4);
    put(3, 16'h01FF, 24'h030000, 8'h9A);
    put(4, 16'hFFFF, 24'h040000, 8'hDC);
    put(5, 16'h00FF, 24'h050000, 8'h72);
    put(6, 16'h002B, 24'h060000, 8'hE1);
    put(7, 16'h1234, 24'h050018, 8'hE4);
    put(8, 16'h2345, 24'h070018, 8'hE6);
    put(9, 16'h3456, 24'h070018, 8'hE7);
    put(10, 16'h4567, 24'h000030, 8'hE5);
    put(11, 16'h5678, 24'h000008, 8'hE4);
    put(12, 16'h6789, 24'h000018, 8'h64);
    put(13, 16'h01FF, 24'h030000, 8'h9A);
    put(17, 16'h00FF, 24'h045600, 8'hF2);
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    ref_chk(2'h2, 2'h0, 16'h0000, 1'b0);
    check(ref_vector === VEC_NOT_PRESENT, "cache after reset");
    load(LD_DATA, 16'h0008, VEC_NONE);
    check(data_seg === 16'h0008 && mem_u.store[6][8] === 1'b1, "data");
    ref_chk(2'h2, 2'h1, 16'h00FF, 1'b1);
    ref_chk(2'h2, 2'h1, 16'h0100, 1'b0);
    check(ref_base === 24'h012340, "data base");
    load(LD_STACK, 16'h000B, VEC_NONE);
    check(stack_seg === 16'h000B, "stack selector");
    load(LD_EXTRA, 16'h0013, VEC_NONE);
    ref_chk(2'h3, 2'h1, 16'h1000, 1'b0);
    ref_chk(2'h3, 2'h0, 16'h0FFF, 1'b0);
    ref_chk(2'h3, 2'h0, 16'h1000, 1'b1);
    load(LD_CODE, 16'h0018, VEC_NONE);
    ref_chk(2'h0, 2'h0, 16'h0000, 1'b1);
    ref_chk(2'h0, 2'h1, 16'h0000, 1'b0);
    ref_chk(2'h0, 2'h2, 16'h01FF, 1'b1);
    ref_chk(2'h0, 2'h2, 16'h0200, 1'b0);
    load(LD_CODE, 16'h0020, VEC_NONE);
    ref_chk(2'h0, 2'h2, 16'h0000, 1'b1);
    ref_chk(2'h0, 2'h0, 16'h0000, 1'b0);
    current_ring = 2'h1;
    ref_chk(2'h0, 2'h2, 16'h0000, 1'b0);
    current_ring = 2'h3;
    load(LD_DATA, 16'h0028, VEC_NOT_PRESENT);
    check(data_seg === 16'h0008, "data kept");
    ref_chk(2'h2, 2'h0, 16'h0000, 1'b1);
    load(LD_DATA, 16'h0030, VEC_PROTECTION);
    load(LD_DATA, 16'h0080, VEC_PROTECTION);
    load(LD_DATA, 16'h0000, VEC_PROTECTION);
    load(LD_DATA, 16'h000F, VEC_NONE);
    ref_chk(2'h2, 2'h0, 16'h0000, 1'b1);
    check(ref_base === 24'h045600, "local base");
    delay = 4'h3;
    gate(16'h0038, TYPE_CALL_GATE, 16'h0018, 5'h05, 1'b0);
    check(gate_dest_offset === 16'h1234, "entry offset");
    gate(16'h0040, TYPE_IRQ_GATE, 16'h0018, 5'h00, 1'b1);
    gate(16'h0048, TYPE_TRAP_GATE, 16'h0018, 5'h00, 1'b0);
    gate(16'h0050, TYPE_TASK_GATE, 16'h0030, 5'h00, 1'b0);
    load(LD_GATE, 16'h0058, VEC_PROTECTION);
    load(LD_GATE, 16'h0060, VEC_NOT_PRESENT);
    load(LD_TEST, 16'h0068, VEC_NONE);
    check(mem_u.store[54][8] === 1'b1 && code_seg === 16'h0020, "test");
    wrap_up();
  end
endmodule : test_seg_protect
